// File: common/fcs_map.svh
// register offsets, reset values, field positions and timeout counts
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
// ----------------------------------------
// register offsets in extended register space
// ----------------------------------------
`define FCS_OFS_CMD 16'ha020
`define FCS_OFS_DAT 16'ha021
`define FCS_OFS_ADH 16'ha022
`define FCS_OFS_ADL 16'ha023
`define FCS_OFS_SCL 16'ha024
`define FCS_OFS_PLO 16'ha025
`define FCS_OFS_PHI 16'ha026
`define FCS_OFS_ADM 16'ha012
// ----------------------------------------
// reset values
// ----------------------------------------
`define FCS_RST_CMD 8'h80
`define FCS_RST_DAT 8'h00
`define FCS_RST_ADR 8'h00
`define FCS_RST_SCL 8'h25
`define FCS_RST_PLO 8'hff
`define FCS_RST_PHI 8'h00
// ----------------------------------------
// command register fields
// ----------------------------------------
`define FCS_VFY_BIT 7
`define FCS_FAIL_BIT 5
`define FCS_CYC_HI 7
`define FCS_CYC_LO 5
`define FCS_CMD_HI 4
`define FCS_BIT_MRD 4
`define FCS_BIT_ERS 3
`define FCS_BIT_MWR 2
`define FCS_BIT_IRD 1
`define FCS_BIT_IWR 0
// lowest information block byte writable outside writer mode
`define FCS_IFB_USER 8'h40
// ----------------------------------------
// pulse lengths in time-base ticks
// ----------------------------------------
`define FCS_WR_0 14'd55
`define FCS_WR_1 14'd60
`define FCS_WR_2 14'd65
`define FCS_WR_3 14'd69
`define FCS_WR_4 14'd75
`define FCS_WR_5 14'd80
`define FCS_WR_6 14'd85
`define FCS_WR_7 14'd89
`define FCS_ER_0 14'd5435
`define FCS_ER_1 14'd5953
`define FCS_ER_2 14'd6452
`define FCS_ER_3 14'd6897
`define FCS_ER_4 14'd7408
`define FCS_ER_5 14'd7906
`define FCS_ER_6 14'd8404
`define FCS_ER_7 14'd8889
`endif

// File: common/fcs_pkg.sv
// types shared by the flash command sequencer
package fcs_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RD_WAIT = 3'b001,
      ST_RD_CAP = 3'b010,
      ST_PULSE = 3'b011,
      ST_VF_WAIT = 3'b100,
      ST_VF_CAP = 3'b101
   } fcs_state_e;
   // request to the flash array
   typedef struct packed {
      logic [16:0] addr;
      logic [7:0] wdata;
      logic information_block;
      logic rd;
      logic prog;
      logic erase;
   } fcs_flash_s;
endpackage : fcs_pkg

// File: rtl/fcs_flash_command_sequencer.sv
// flash command sequencer: registers, checks, pulse timing and verify
`timescale 1ns/1ps
`include "fcs_map.svh"
// Notes on behaviour
// R1 - stall cpu while a command runs
// R2 - main array sectors are 1024 bytes
// R3 - information block is separate 256-byte sector
// R4 - read back after write, clear verify on mismatch
// R5 - verify flag set again on each command
// R6 - fail flag cleared only by new command
// R7 - out of range or protected aborts with fail
// R8 - software checks fail after each command
// R9 - timeout select picks write and erase counts
// R10 - software uses timeout select 111 normally
// R11 - time base from system clock via scaler
// R12 - software sets time base near 2 MHz
// R13 - command code decoded one-hot
// R14 - other codes not executed, fail set
// R15 - outside writer mode, info block writes only at 0x40 to 0xff
// R16 - address from three registers, data from port
// R17 - erase uses sector bits, clears whole sector
// R18 - check protection bounds before erase or write
// R19 - fuse area writable only in writer mode
// R20 - data port reads last read, writes next byte
// R21 - low bound protects zero up to bound
// R22 - high bound protects above bound to top
// R23 - command write launches, status reads flags
// R24 - pulses timed in ticks to selected count
module fcs_flash_command_sequencer (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // cpu hold
   output logic cpu_stall,
   // writer mode pin
   input wire logic writer_mode,
   // flash array
   output fcs_pkg::fcs_flash_s flash_req,
   input wire logic [7:0] flash_rdata
);

   // ----------------------------------------
   // functions
   // ----------------------------------------

   // write pulse length for a timeout code
   function automatic logic [13:0] wr_ticks(input logic [2:0] c);
      case (c) // R9
         3'h0: wr_ticks = `FCS_WR_0;
         3'h1: wr_ticks = `FCS_WR_1;
         3'h2: wr_ticks = `FCS_WR_2;
         3'h3: wr_ticks = `FCS_WR_3;
         3'h4: wr_ticks = `FCS_WR_4;
         3'h5: wr_ticks = `FCS_WR_5;
         3'h6: wr_ticks = `FCS_WR_6;
         default: wr_ticks = `FCS_WR_7;
      endcase
   endfunction : wr_ticks

   // erase pulse length for a timeout code
   function automatic logic [13:0] er_ticks(input logic [2:0] c);
      case (c) // R9
         3'h0: er_ticks = `FCS_ER_0;
         3'h1: er_ticks = `FCS_ER_1;
         3'h2: er_ticks = `FCS_ER_2;
         3'h3: er_ticks = `FCS_ER_3;
         3'h4: er_ticks = `FCS_ER_4;
         3'h5: er_ticks = `FCS_ER_5;
         3'h6: er_ticks = `FCS_ER_6;
         default: er_ticks = `FCS_ER_7;
      endcase
   endfunction : er_ticks

   // page range hits a protected zone
   function automatic logic prot_hit(input logic [8:0] pg_lo,
                                     input logic [8:0] pg_hi,
                                     input logic [7:0] lo_b,
                                     input logic [7:0] hi_b);
      prot_hit = (pg_lo <= {1'b0, lo_b}) || (pg_hi > {1'b0, hi_b}); // R21 R22
   endfunction : prot_hit

   // ----------------------------------------
   // registers
   // ----------------------------------------
   fcs_pkg::fcs_state_e state_r; // sequencer state
   fcs_pkg::fcs_flash_s req_r; // array request
   logic [7:0] adm_r; // address top byte
   logic [7:0] adh_r; // address high byte
   logic [7:0] adl_r; // address low byte
   logic [7:0] dwr_r; // byte for next write
   logic [7:0] drd_r; // last byte read
   logic [7:0] scl_r; // time-base scaler
   logic [7:0] plo_r; // low protection bound
   logic [7:0] phi_r; // high protection bound
   logic [4:0] cmd_r; // last command code
   logic [2:0] cyc_r; // latched timeout code
   logic vfy_r; // write verify flag
   logic fail_r; // command fail flag
   logic [7:0] acc_r; // time-base accumulator
   logic [13:0] cnt_r; // ticks in pulse
   logic [13:0] lim_r; // pulse length
   logic [7:0] rdata_r; // read data out
   logic wm_s1_r; // writer mode sync stage 1
   logic wm_s2_r; // writer mode sync stage 2

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire logic idle = (state_r == fcs_pkg::ST_IDLE);
   wire logic sel_cmd = (reg_addr == `FCS_OFS_CMD);
   wire logic sel_dat = (reg_addr == `FCS_OFS_DAT);
   wire logic sel_adh = (reg_addr == `FCS_OFS_ADH);
   wire logic sel_adl = (reg_addr == `FCS_OFS_ADL);
   wire logic sel_adm = (reg_addr == `FCS_OFS_ADM);
   wire logic sel_scl = (reg_addr == `FCS_OFS_SCL);
   wire logic sel_plo = (reg_addr == `FCS_OFS_PLO);
   wire logic sel_phi = (reg_addr == `FCS_OFS_PHI);
   // writes land only while idle, the cpu is held otherwise
   wire logic wr_ok = reg_wr && idle;
   wire logic launch = wr_ok && sel_cmd; // R23
   wire logic [4:0] code = reg_wdata[`FCS_CMD_HI:0];
   wire logic [2:0] cyc_in = reg_wdata[`FCS_CYC_HI:`FCS_CYC_LO];
   // one-hot command bits
   wire logic c_mrd = (code == 5'h10); // R13
   wire logic c_ers = (code == 5'h08); // R13
   wire logic c_mwr = (code == 5'h04); // R13
   wire logic c_ird = (code == 5'h02); // R13
   wire logic c_iwr = (code == 5'h01); // R13
   wire logic c_ok = c_mrd | c_ers | c_mwr | c_ird | c_iwr; // R14
   // full byte address
   wire logic [16:0] addr = {adm_r[0], adh_r, adl_r}; // R16
   // main array is 128k, information block 256 bytes
   wire logic oor_main = |adm_r[7:1]; // R2 R7
   wire logic oor_ifb = (|adm_r) | (|adh_r); // R3 R7
   wire logic oor = (c_ird | c_iwr) ? oor_ifb : oor_main;
   // sector of 1024 bytes spans four 256-byte pages
   wire logic [8:0] pg_s = {addr[16:10], 2'b00}; // R2 R17
   wire logic [8:0] pg_e = {addr[16:10], 2'b11}; // R17
   wire logic p_ers = prot_hit(pg_s, pg_e, plo_r, phi_r); // R18
   wire logic p_wr = prot_hit(addr[16:8], addr[16:8], plo_r, phi_r); // R18
   wire logic prot = (c_ers & p_ers) | (c_mwr & p_wr);
   // manufacturer and fuse bytes need writer mode
   wire logic fuse = c_iwr && (adl_r < `FCS_IFB_USER) && !wm_s2_r; // R15 R19
   wire logic reject = !c_ok || oor || prot || fuse; // R7 R14
   wire logic go = launch && !reject;
   // time-base tick: system clock times (scaler+1)/256
   wire logic [8:0] acc_sum = {1'b0, acc_r} + {1'b0, scl_r} + 9'h001; // R11
   wire logic tick = acc_sum[8]; // R11
   wire logic pulse_end = (state_r == fcs_pkg::ST_PULSE) && tick
                          && (cnt_r == lim_r - 14'd1); // R24
   // status read value
   wire logic [7:0] stat = {vfy_r, 1'b0, fail_r, cmd_r}; // R23
   wire logic [7:0] rd_mux = sel_cmd ? stat :
                             sel_dat ? drd_r : // R20
                             sel_adh ? adh_r :
                             sel_adl ? adl_r :
                             sel_adm ? adm_r :
                             sel_scl ? scl_r :
                             sel_plo ? plo_r :
                             sel_phi ? phi_r : 8'h00;

   assign cpu_stall = !idle; // R1
   assign flash_req = req_r;
   assign reg_rdata = rdata_r;

   // ----------------------------------------
   // writer mode synchroniser
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wm_s1_r <= 1'b0;
         wm_s2_r <= 1'b0;
      end else begin
         wm_s1_r <= writer_mode;
         wm_s2_r <= wm_s1_r;
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         adm_r <= `FCS_RST_ADR;
         adh_r <= `FCS_RST_ADR;
         adl_r <= `FCS_RST_ADR;
         dwr_r <= `FCS_RST_DAT;
         scl_r <= `FCS_RST_SCL;
         plo_r <= `FCS_RST_PLO;
         phi_r <= `FCS_RST_PHI;
         rdata_r <= 8'h00;
      end else begin
         if (wr_ok && sel_adm) adm_r <= reg_wdata;
         if (wr_ok && sel_adh) adh_r <= reg_wdata;
         if (wr_ok && sel_adl) adl_r <= reg_wdata;
         if (wr_ok && sel_dat) dwr_r <= reg_wdata; // R20
         if (wr_ok && sel_scl) scl_r <= reg_wdata;
         if (wr_ok && sel_plo) plo_r <= reg_wdata;
         if (wr_ok && sel_phi) phi_r <= reg_wdata;
         if (reg_rd) rdata_r <= rd_mux;
      end
   end

   // ----------------------------------------
   // result flags
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         vfy_r <= 1'b1;
         fail_r <= 1'b0;
         cmd_r <= 5'h00;
         cyc_r <= 3'h0;
      end else if (launch) begin
         // a new command restarts both flags
         vfy_r <= 1'b1; // R5
         fail_r <= reject; // R6 R7
         cmd_r <= code;
         cyc_r <= cyc_in;
      end else if (state_r == fcs_pkg::ST_VF_CAP && flash_rdata != req_r.wdata) begin
         vfy_r <= 1'b0; // R4
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= fcs_pkg::ST_IDLE;
         req_r <= '0;
         drd_r <= 8'h00;
         acc_r <= 8'h00;
         cnt_r <= 14'd0;
         lim_r <= 14'd0;
      end else begin
         case (state_r)
            fcs_pkg::ST_IDLE: begin
               acc_r <= 8'h00;
               cnt_r <= 14'd0;
               if (go) begin
                  // erase points at sector base
                  req_r.addr <= c_ers ? {addr[16:10], 10'h000} : addr; // R16 R17
                  req_r.wdata <= dwr_r; // R16
                  req_r.information_block <= c_ird | c_iwr; // R3
                  req_r.rd <= c_mrd | c_ird;
                  req_r.prog <= c_mwr | c_iwr;
                  req_r.erase <= c_ers; // R17
                  lim_r <= c_ers ? er_ticks(cyc_in) : wr_ticks(cyc_in); // R9
                  state_r <= (c_mrd | c_ird) ? fcs_pkg::ST_RD_WAIT : fcs_pkg::ST_PULSE;
               end
            end
            fcs_pkg::ST_RD_WAIT: begin
               // array answers one cycle after the strobe
               req_r.rd <= 1'b0;
               state_r <= fcs_pkg::ST_RD_CAP;
            end
            fcs_pkg::ST_RD_CAP: begin
               drd_r <= flash_rdata; // R20
               state_r <= fcs_pkg::ST_IDLE;
            end
            fcs_pkg::ST_PULSE: begin
               acc_r <= acc_sum[7:0];
               if (tick) cnt_r <= cnt_r + 14'd1; // R24
               if (pulse_end) begin
                  req_r.prog <= 1'b0;
                  req_r.erase <= 1'b0;
                  // writes are read back, erases end here
                  req_r.rd <= req_r.prog; // R4
                  state_r <= req_r.prog ? fcs_pkg::ST_VF_WAIT : fcs_pkg::ST_IDLE;
               end
            end
            fcs_pkg::ST_VF_WAIT: begin
               req_r.rd <= 1'b0;
               state_r <= fcs_pkg::ST_VF_CAP;
            end
            fcs_pkg::ST_VF_CAP: begin
               state_r <= fcs_pkg::ST_IDLE;
            end
            default: begin
               req_r <= '0;
               state_r <= fcs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   stall_on_go_a: assert property (go |=> cpu_stall) // R1
      else $error("cpu not held after accepted command");
   reject_fail_a: assert property (launch && reject |=> fail_r && !cpu_stall) // R7
      else $error("refused command did not fail at once");
   bad_code_a: assert property (launch && !c_ok |=> fail_r && idle) // R14
      else $error("invalid code was executed");
   vfy_restart_a: assert property (launch |=> vfy_r) // R5
      else $error("verify flag not set by new command");
   mismatch_a: assert property (state_r == fcs_pkg::ST_VF_CAP
         && flash_rdata != req_r.wdata |=> !vfy_r) // R4
      else $error("write mismatch not flagged");
   fail_hold_a: assert property (!launch |=> $stable(fail_r)) // R6
      else $error("fail flag changed without a command");
   fuse_lock_a: assert property (launch && c_iwr && adl_r < `FCS_IFB_USER
         && !wm_s2_r |=> fail_r) // R15
      else $error("protected info byte write accepted");
   erase_base_a: assert property (req_r.erase |-> req_r.addr[9:0] == 10'h000) // R17
      else $error("erase address not sector aligned");
   pulse_end_a: assert property (pulse_end |=> !req_r.prog && !req_r.erase
         && $past(cnt_r) == lim_r - 14'd1) // R24
      else $error("pulse ended at wrong count");
   read_cap_a: assert property (state_r == fcs_pkg::ST_RD_CAP
         |=> drd_r == $past(flash_rdata)) // R20
      else $error("read byte not kept in data port");

   read_cv: cover property (launch && c_mrd && !reject ##2 state_r == fcs_pkg::ST_RD_CAP);
   erase_cv: cover property (req_r.erase ##1 !req_r.erase);
   bad_vfy_cv: cover property (state_r == fcs_pkg::ST_VF_CAP ##1 !vfy_r);

endmodule : fcs_flash_command_sequencer

// File: test/fcs_flash_model.sv
// behavioural model of the embedded flash array behind the sequencer
`timescale 1ns/1ps
module fcs_flash_model (
   // clock
   input wire logic core_clk,
   // array request and read answer
   input wire fcs_pkg::fcs_flash_s flash_req,
   output logic [7:0] flash_rdata
);
   logic [7:0] mem [logic [17:0]]; // sparse store keyed {ifb, addr}, blank reads ff
   logic busy_q = 1'b0; // prog or erase was high last cycle
   fcs_pkg::fcs_flash_s req_q; // request held over the pulse
   int i; // erase walk index
   initial flash_rdata = 8'h00;
   // byte as stored, blank cells read ff
   function automatic logic [7:0] peek(input logic [17:0] k);
      return mem.exists(k) ? mem[k] : 8'hff;
   endfunction : peek
   // pulse end commits first, so a read in the same edge sees the new byte
   always @(posedge core_clk) begin
      busy_q <= flash_req.prog | flash_req.erase;
      if (flash_req.prog | flash_req.erase) req_q <= flash_req;
      if (busy_q && !(flash_req.prog | flash_req.erase)) begin
         // programming only clears bits, as real cells do
         if (req_q.prog) mem[{req_q.information_block, req_q.addr}] = peek({req_q.information_block, req_q.addr}) & req_q.wdata;
         // erase fills the whole 1024-byte sector
         if (req_q.erase) for (i = 0; i < 1024; i++) mem[{1'b0, req_q.addr[16:10], i[9:0]}] = 8'hff;
      end
      // answer one cycle after rd, otherwise the bus wanders
      if (flash_req.rd) flash_rdata <= peek({flash_req.information_block, flash_req.addr});
      else flash_rdata <= ~flash_rdata;
   end
endmodule : fcs_flash_model

// File: test/flash_command_sequencer_bench.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`include "fcs_map.svh"
module flash_command_sequencer_bench;
   // ----
   // signals
   // ----
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic cpu_stall;
   logic writer_mode = 1'b0;
   fcs_pkg::fcs_flash_s flash_req;
   logic [7:0] flash_rdata;
   int fails = 0;
   int checked = 0;
   int stall_n; // cycles with the cpu held
   int pulse_n; // cycles with prog or erase high
   logic [16:0] req_addr; // address of the first array request
   logic [7:0] rd_v; // last register read
   int wr_tab[8] = '{55, 60, 65, 69, 75, 80, 85, 89}; // write ticks per select
   always #12.5 core_clk = ~core_clk;
   fcs_flash_command_sequencer u_dut (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .cpu_stall(cpu_stall), .writer_mode(writer_mode), .flash_req(flash_req),
      .flash_rdata(flash_rdata));
   fcs_flash_model u_flash (.core_clk(core_clk), .flash_req(flash_req),
      .flash_rdata(flash_rdata));
   // ----
   // helpers
   // ----
   task automatic conclude();
      if (fails == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // one-cycle write strobe
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // one-cycle read strobe, data taken the cycle after
   task automatic rd(input logic [15:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      rd_v = reg_rdata;
   endtask : rd
   task automatic setadr(input logic [7:0] t, input logic [7:0] h, input logic [7:0] l);
      wr(`FCS_OFS_ADM, t);
      wr(`FCS_OFS_ADH, h);
      wr(`FCS_OFS_ADL, l);
   endtask : setadr
   // count stall and pulse cycles until the cpu is released
   task automatic wait_done();
      int n;
      #1;
      stall_n = 0;
      pulse_n = 0;
      req_addr = 17'h1ffff;
      for (n = 0; n < 20000 && cpu_stall === 1'b1; n++) begin
         stall_n++;
         if (req_addr === 17'h1ffff && (flash_req.rd | flash_req.prog | flash_req.erase))
            req_addr = flash_req.addr;
         if (flash_req.prog === 1'b1 || flash_req.erase === 1'b1) pulse_n++;
         @(posedge core_clk);
         #1;
      end
      if (n == 20000) begin
         fails++;
         conclude();
      end
   endtask : wait_done
   task automatic run(input logic [7:0] c);
      wr(`FCS_OFS_CMD, c);
      wait_done();
   endtask : run
   task automatic stat(input logic [7:0] e);
      rd(`FCS_OFS_CMD);
      cmp(rd_v, e);
   endtask : stat
   // ----
   // scenarios
   // ----
   task automatic t_reset();
      rd(`FCS_OFS_CMD); cmp(rd_v, 8'h80);
      rd(`FCS_OFS_DAT); cmp(rd_v, 8'h00);
      rd(`FCS_OFS_SCL); cmp(rd_v, 8'h25);
      rd(`FCS_OFS_PLO); cmp(rd_v, 8'hff);
      rd(`FCS_OFS_PHI); cmp(rd_v, 8'h00);
      rd(16'ha027); cmp(rd_v, 8'h00);
   endtask : t_reset
   // writes refused by each bound; fail survives reads
   task automatic t_protect();
      setadr(8'h00, 8'h10, 8'h00);
      run(8'h04); cmp(stall_n, 0);
      stat(8'ha4); stat(8'ha4);
      wr(`FCS_OFS_PLO, 8'h10);
      wr(`FCS_OFS_PHI, 8'hff);
      run(8'h04); cmp(stall_n, 0);
      wr(`FCS_OFS_PLO, 8'h0f);
      wr(`FCS_OFS_PHI, 8'h0f);
      run(8'h04); stat(8'ha4);
      wr(`FCS_OFS_PHI, 8'hff);
      wr(`FCS_OFS_PLO, 8'h00);
   endtask : t_protect
   // every timeout select, then read back each byte
   task automatic t_write();
      for (int c = 0; c < 8; c++) begin
         setadr(8'h00, 8'h20, 8'(c));
         wr(`FCS_OFS_DAT, 8'ha0 + 8'(c));
         run({c[2:0], 5'h04});
         cmp(pulse_n, wr_tab[c]);
         cmp(stall_n, wr_tab[c] + 2);
         cmp(req_addr, 17'h02000 + c);
         stat(8'h84);
         run(8'h10); stat(8'h90);
         rd(`FCS_OFS_DAT); cmp(rd_v, 8'ha0 + 8'(c));
      end
   endtask : t_write
   // readback mismatch drops verify, next command restores it
   task automatic t_verify();
      setadr(8'h00, 8'h20, 8'h00);
      wr(`FCS_OFS_DAT, 8'h0f);
      run(8'h04); stat(8'h04);
      run(8'h10); stat(8'h90);
   endtask : t_verify
   task automatic t_invalid();
      logic [4:0] codes [5] = '{5'h03, 5'h12, 5'h00, 5'h18, 5'h1f};
      foreach (codes[k]) begin
         run({3'h7, codes[k]}); cmp(stall_n, 0);
         stat({3'h5, codes[k]});
      end
      run(8'h10); stat(8'h90);
   endtask : t_invalid
   task automatic t_range();
      setadr(8'h02, 8'h00, 8'h00);
      run(8'h10); cmp(stall_n, 0); stat(8'hb0);
      setadr(8'h01, 8'h23, 8'h00);
      run(8'h10); cmp(stall_n, 2); cmp(req_addr, 17'h12300);
   endtask : t_range
   // manufacturer bytes need writer mode
   task automatic t_ifb();
      setadr(8'h00, 8'h00, 8'h3f);
      wr(`FCS_OFS_DAT, 8'h3c);
      run(8'h01); stat(8'ha1);
      setadr(8'h00, 8'h00, 8'h40);
      run(8'h01); stat(8'h81);
      // main byte at the same offset stays blank, info byte keeps its value
      run(8'h10); stat(8'h90); rd(`FCS_OFS_DAT); cmp(rd_v, 8'hff);
      run(8'h02); stat(8'h82); rd(`FCS_OFS_DAT); cmp(rd_v, 8'h3c);
      // info block has no byte above 0xff
      setadr(8'h00, 8'h20, 8'h40);
      run(8'h02); cmp(stall_n, 0); stat(8'ha2);
      writer_mode <= 1'b1;
      repeat (3) @(posedge core_clk);
      setadr(8'h00, 8'h00, 8'h3f);
      run(8'h01); stat(8'h81);
      writer_mode <= 1'b0;
   endtask : t_ifb
   // register writes are ignored while the cpu is held
   task automatic t_stall();
      setadr(8'h00, 8'h30, 8'h05);
      wr(`FCS_OFS_CMD, 8'h04);
      wr(`FCS_OFS_ADL, 8'h77);
      wait_done();
      rd(`FCS_OFS_ADL); cmp(rd_v, 8'h05);
   endtask : t_stall
   task automatic t_erase();
      setadr(8'h00, 8'h20, 8'h03);
      run(8'h08); cmp(pulse_n, 5435); cmp(req_addr, 17'h02000);
      stat(8'h88);
      setadr(8'h00, 8'h23, 8'hff);
      run(8'h10); rd(`FCS_OFS_DAT); cmp(rd_v, 8'hff);
      // a byte programmed earlier in the sector is blank again
      setadr(8'h00, 8'h20, 8'h05);
      run(8'h10); rd(`FCS_OFS_DAT); cmp(rd_v, 8'hff);
      setadr(8'h00, 8'h40, 8'h00);
      run(8'he8); cmp(pulse_n, 8889);
   endtask : t_erase
   // half-rate time base doubles the pulse
   task automatic t_scale();
      wr(`FCS_OFS_SCL, 8'h7f);
      setadr(8'h00, 8'h50, 8'h00);
      run(8'h04); cmp(pulse_n, 110);
      wr(`FCS_OFS_SCL, 8'hff);
   endtask : t_scale
   // ----
   // main sequence
   // ----
   initial begin
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      t_reset();
      t_protect();
      wr(`FCS_OFS_SCL, 8'hff);
      t_write();
      t_verify();
      t_invalid();
      t_range();
      t_ifb();
      t_stall();
      t_erase();
      t_scale();
      conclude();
   end
endmodule : flash_command_sequencer_bench
